// ### rtl/speed_threshold_relay_control.sv
// Frequency threshold relay controller with Wishbone registers
//
// Our own choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ns
`include "speed_threshold_defines.svh"
module speed_threshold_relay_control #(
  parameter logic [31:0] CYCLES_PER_MS  = `CYC_PER_MS,
  parameter logic [31:0] MAX_PERIOD_CYC = `MAX_PERIOD_CYC
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Sensor and control pins
  input  wire logic        sensor_i,
  input  wire logic        override_n_i,
  input  wire logic        clear_n_i,
  // Relay and indicators
  output logic             relay_o,
  output logic             relay_led_o,
  output logic             input_led_o
);
  localparam logic [79:0] FREQ_SCALE = 80'(CYCLES_PER_MS) * 80'(`FREQ_SCALE_MS);

  logic [31:0]                     ctrl;
  speed_threshold_pkg::freq_t      trip_freq;
  logic                            sensor_lvl;
  logic                            override_lvl;
  logic                            clear_lvl;
  logic                            sensor_prev;
  logic                            fall;
  speed_threshold_pkg::meas_state_t state;
  logic [31:0]                     elapsed;
  logic [17:0]                     edges;
  logic [31:0]                     elapsed_last;
  logic [17:0]                     edges_last;
  logic [31:0]                     win_cycles;
  logic [15:0]                     win_ms;
  logic                            win_done;
  logic                            eval_done;
  logic                            trip_region;
  logic                            release_region;
  logic                            suppressed;
  logic                            override_prev;
  logic                            relay;
  speed_threshold_pkg::mode_t      mode;
  logic                            overspeed;
  logic                            latching;
  logic                            startup_ign;
  logic [15:0]                     ofs_frac;
  logic [15:0]                     hys_frac;
  logic [37:0]                     ofs_prod;
  logic [37:0]                     hys_prod;
  logic [23:0]                     ofs_val;
  logic [23:0]                     hys_val;
  logic [23:0]                     trip_pt;
  logic [23:0]                     release_pt;
  logic [79:0]                     meas_lhs;
  logic [79:0]                     trip_rhs;
  logic [79:0]                     rel_rhs;
  logic                            next_trip_region;
  logic                            next_release_region;
  logic                            override_active;
  logic                            clear_active;
  logic                            wb_req;
  logic [31:0]                     rd_data;

  // Pin synchronisers
  input_sync sensor_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   (sensor_i),
    .level_o (sensor_lvl)
  );

  input_sync override_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   (override_n_i),
    .level_o (override_lvl)
  );

  input_sync clear_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   (clear_n_i),
    .level_o (clear_lvl)
  );

  assign override_active = ~override_lvl;
  assign clear_active    = ~clear_lvl;

  // Mode decode; unknown codes behave as overspeed automatic
  assign mode = ctrl[`CTRL_MODE_MSB:`CTRL_MODE_LSB];

  always_comb
  begin
    overspeed   = 1'b1;
    latching    = 1'b0;
    startup_ign = 1'b0;
    case (mode)
      `MODE_OVER_AUTO:   overspeed = 1'b1;
      `MODE_OVER_LATCH:  latching = 1'b1;
      `MODE_UNDER_AUTO:  overspeed = 1'b0;
      `MODE_UNDER_IGN:
      begin
        overspeed   = 1'b0;
        startup_ign = 1'b1;
      end
      `MODE_UNDER_LATCH:
      begin
        overspeed = 1'b0;
        latching  = 1'b1;
      end
      `MODE_UNDER_LIGN:
      begin
        overspeed   = 1'b0;
        latching    = 1'b1;
        startup_ign = 1'b1;
      end
      default: overspeed = 1'b1;
    endcase
  end

  // Averaging window length
  always_comb
  begin
    case (ctrl[`CTRL_WIN_MSB:`CTRL_WIN_LSB])
      4'h0:    win_ms = `WIN_MS_0;
      4'h1:    win_ms = `WIN_MS_1;
      4'h2:    win_ms = `WIN_MS_2;
      4'h3:    win_ms = `WIN_MS_3;
      4'h4:    win_ms = `WIN_MS_4;
      4'h5:    win_ms = `WIN_MS_5;
      4'h6:    win_ms = `WIN_MS_6;
      4'h7:    win_ms = `WIN_MS_7;
      4'h8:    win_ms = `WIN_MS_8;
      4'h9:    win_ms = `WIN_MS_9;
      default: win_ms = `WIN_MS_9;
    endcase
  end

  assign win_cycles = 32'(48'(win_ms) * 48'(CYCLES_PER_MS));

  // Fraction of the trip frequency for a step code
  function automatic logic [15:0] frac_of(input logic [3:0] code);
    case (code)
      4'h1:    frac_of = `FRAC_1;
      4'h2:    frac_of = `FRAC_2;
      4'h3:    frac_of = `FRAC_3;
      4'h4:    frac_of = `FRAC_4;
      4'h5:    frac_of = `FRAC_5;
      4'h6:    frac_of = `FRAC_6;
      4'h7:    frac_of = `FRAC_7;
      4'h8:    frac_of = `FRAC_8;
      4'h9:    frac_of = `FRAC_9;
      default: frac_of = `FRAC_OFF;
    endcase
  endfunction

  assign ofs_frac = frac_of(ctrl[`CTRL_OFS_MSB:`CTRL_OFS_LSB]);
  assign hys_frac = frac_of(ctrl[`CTRL_HYS_MSB:`CTRL_HYS_LSB]);
  assign ofs_prod = 38'(trip_freq) * 38'(ofs_frac);
  assign hys_prod = 38'(trip_freq) * 38'(hys_frac);
  assign ofs_val  = 24'(ofs_prod >> `FRAC_SHIFT);
  assign hys_val  = 24'(hys_prod >> `FRAC_SHIFT);

  // Trip and release points in centihertz
  always_comb
  begin
    if (overspeed)
    begin
      trip_pt    = 24'(trip_freq) + ofs_val;
      release_pt = trip_pt - hys_val;
    end
    else
    begin
      trip_pt    = 24'(trip_freq) - ofs_val;
      release_pt = trip_pt + hys_val;
    end
  end

  // Average frequency compared by cross multiplication
  assign meas_lhs = 80'(edges_last) * FREQ_SCALE;
  assign trip_rhs = 80'(trip_pt) * 80'(elapsed_last);
  assign rel_rhs  = 80'(release_pt) * 80'(elapsed_last);

  always_comb
  begin
    if (overspeed)
    begin
      next_trip_region    = meas_lhs > trip_rhs;
      next_release_region = meas_lhs < rel_rhs;
    end
    else
    begin
      next_trip_region    = meas_lhs < trip_rhs;
      next_release_region = meas_lhs > rel_rhs;
    end
  end

  // Falling edge detection of the conditioned sensor
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      sensor_prev <= 1'b1;
    else
      sensor_prev <= sensor_lvl;
  end

  assign fall = sensor_prev & ~sensor_lvl;

  // Window measurement: minimum time, then wait for the next falling edge
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state    <= speed_threshold_pkg::MEAS_MIN;
      elapsed  <= 32'h00000000;
      edges    <= 18'h00000;
      win_done <= 1'b0;
    end
    else
    begin
      win_done <= 1'b0;
      case (state)
        speed_threshold_pkg::MEAS_MIN:
        begin
          elapsed <= elapsed + 32'h00000001;
          edges   <= edges + 18'(fall);
          if (elapsed >= win_cycles - 32'h00000001)
          begin
            if (fall || edges == 18'h00000)
            begin
              win_done <= 1'b1;
              elapsed  <= 32'h00000000;
              edges    <= 18'h00000;
            end
            else
              state <= speed_threshold_pkg::MEAS_EDGE;
          end
        end
        speed_threshold_pkg::MEAS_EDGE:
        begin
          elapsed <= elapsed + 32'h00000001;
          if (fall || elapsed >= MAX_PERIOD_CYC)
          begin
            win_done <= 1'b1;
            elapsed  <= 32'h00000000;
            edges    <= 18'h00000;
            state    <= speed_threshold_pkg::MEAS_MIN;
          end
        end
        default:
        begin
          state   <= speed_threshold_pkg::MEAS_MIN;
          elapsed <= 32'h00000000;
          edges   <= 18'h00000;
        end
      endcase
    end
  end

  // Capture of the finished window
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      elapsed_last <= 32'h00000001;
      edges_last   <= 18'h00000;
    end
    else if (state == speed_threshold_pkg::MEAS_MIN && !win_done && elapsed >= win_cycles
             - 32'h00000001 && (fall || edges == 18'h00000))
    begin
      elapsed_last <= elapsed + 32'h00000001;
      edges_last   <= edges + 18'(fall);
    end
    else if (state == speed_threshold_pkg::MEAS_EDGE && (fall || elapsed >= MAX_PERIOD_CYC))
    begin
      elapsed_last <= elapsed + 32'h00000001;
      edges_last   <= edges + 18'(fall);
    end
  end

  // Region evaluation one cycle after the window closes
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      trip_region    <= 1'b0;
      release_region <= 1'b0;
      eval_done      <= 1'b0;
    end
    else
    begin
      eval_done <= win_done;
      if (win_done)
      begin
        trip_region    <= next_trip_region;
        release_region <= next_release_region;
      end
    end
  end

  // Start-up suppression ends the first time the release region is reached
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      suppressed <= 1'b1;
    else if (eval_done && release_region)
      suppressed <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      override_prev <= 1'b0;
    else
      override_prev <= override_active;
  end

  // Relay decision
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      relay <= 1'b0;
    else if (override_active)
      relay <= 1'b0;
    else if (eval_done || override_prev)
    begin
      if (!relay)
      begin
        if (trip_region && !(startup_ign && suppressed))
          relay <= 1'b1;
      end
      else if (release_region && (!latching || clear_active))
        relay <= 1'b0;
    end
    else if (relay && latching && clear_active && release_region && !trip_region)
      relay <= 1'b0;
  end

  // Relay and indicator outputs
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      relay_o     <= 1'b0;
      relay_led_o <= 1'b0;
      input_led_o <= 1'b0;
    end
    else
    begin
      relay_o     <= relay;
      relay_led_o <= relay;
      input_led_o <= sensor_lvl;
    end
  end

  // Wishbone classic slave, one wait state
  assign wb_req = wb_cyc_i & wb_stb_i;

  always_comb
  begin
    rd_data = 32'h00000000;
    case (wb_adr_i)
      `ADDR_CTRL:    rd_data = ctrl;
      `ADDR_TRIP:    rd_data = 32'(trip_freq);
      `ADDR_STATUS:
      begin
        rd_data[`STAT_RELAY]    = relay;
        rd_data[`STAT_TRIP_REG] = trip_region;
        rd_data[`STAT_REL_REG]  = release_region;
        rd_data[`STAT_SUPPRESS] = suppressed;
        rd_data[`STAT_OVERRIDE] = override_active;
        rd_data[`STAT_CLEAR]    = clear_active;
        rd_data[`STAT_INPUT]    = sensor_lvl;
      end
      `ADDR_EDGES:   rd_data = 32'(edges_last);
      `ADDR_ELAPSED: rd_data = elapsed_last;
      default:       rd_data = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= wb_req & ~wb_ack_o;
      if (wb_req && !wb_ack_o)
        wb_dat_o <= rd_data;
    end
  end

  // Byte-lane merge of write data into a register
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] sel, input logic [31:0] mask);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
        res[i*8 +: 8] = new_v[i*8 +: 8];
    end
    merge = res & mask;
  endfunction

  // Writes take effect on the edge where ack is high
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl      <= `CTRL_RST;
      trip_freq <= `TRIP_RST;
    end
    else if (wb_req && wb_we_i && wb_ack_o)
    begin
      if (wb_adr_i == `ADDR_CTRL)
        ctrl <= merge(ctrl, wb_dat_i, wb_sel_i, `CTRL_USED_MASK);
      if (wb_adr_i == `ADDR_TRIP)
        trip_freq <= 22'(merge(32'(trip_freq), wb_dat_i, wb_sel_i, `TRIP_USED_MASK));
    end
  end
endmodule

// ### rtl/speed_threshold_defines.svh
// Constants for the speed threshold relay controller
`ifndef SPEED_THRESHOLD_DEFINES_SVH
`define SPEED_THRESHOLD_DEFINES_SVH

// Clock and time figures
`define CLK_HZ            100000000
`define CYC_PER_MS        (`CLK_HZ / 1000)
`define MAX_PERIOD_S      10
`define MAX_PERIOD_CYC    (`MAX_PERIOD_S * `CLK_HZ)
`define FREQ_SCALE_MS     100000

// Register byte addresses
`define ADDR_CTRL         8'h00
`define ADDR_TRIP         8'h04
`define ADDR_STATUS       8'h08
`define ADDR_EDGES        8'h0C
`define ADDR_ELAPSED      8'h10

// Control register fields
`define CTRL_MODE_LSB     0
`define CTRL_MODE_MSB     2
`define CTRL_WIN_LSB      4
`define CTRL_WIN_MSB      7
`define CTRL_OFS_LSB      8
`define CTRL_OFS_MSB      11
`define CTRL_HYS_LSB      12
`define CTRL_HYS_MSB      15
`define CTRL_USED_MASK    32'h0000FFF7
`define TRIP_USED_MASK    32'h003FFFFF

// Reset values: overspeed automatic, 5 ms window, no offset, 0.25 % hysteresis, 10 kHz
`define CTRL_RST          32'h00001001
`define TRIP_RST          22'h0F4240

// Status register bits
`define STAT_RELAY        0
`define STAT_TRIP_REG     1
`define STAT_REL_REG      2
`define STAT_SUPPRESS     3
`define STAT_OVERRIDE     4
`define STAT_CLEAR        5
`define STAT_INPUT        6

// Operating modes
`define MODE_OVER_AUTO    3'h1
`define MODE_OVER_LATCH   3'h2
`define MODE_UNDER_AUTO   3'h3
`define MODE_UNDER_IGN    3'h4
`define MODE_UNDER_LATCH  3'h5
`define MODE_UNDER_LIGN   3'h6

// Averaging window in milliseconds, ten steps
`define WIN_MS_0          16'h0005
`define WIN_MS_1          16'h000A
`define WIN_MS_2          16'h0014
`define WIN_MS_3          16'h0032
`define WIN_MS_4          16'h0064
`define WIN_MS_5          16'h00C8
`define WIN_MS_6          16'h01F4
`define WIN_MS_7          16'h03E8
`define WIN_MS_8          16'h07D0
`define WIN_MS_9          16'h2710

// Offset and hysteresis fractions of the trip frequency, Q0.16
`define FRAC_SHIFT        16
`define FRAC_OFF          16'h0000
`define FRAC_1            16'h00A4
`define FRAC_2            16'h0148
`define FRAC_3            16'h028F
`define FRAC_4            16'h051F
`define FRAC_5            16'h0CCD
`define FRAC_6            16'h199A
`define FRAC_7            16'h3333
`define FRAC_8            16'h4000
`define FRAC_9            16'h5553

`endif

// ### rtl/speed_threshold_pkg.sv
// Types shared by the speed threshold relay controller
package speed_threshold_pkg;
  typedef logic [2:0]  mode_t;
  typedef logic [21:0] freq_t;
  typedef enum logic [0:0] {MEAS_MIN, MEAS_EDGE} meas_state_t;
endpackage

// ### rtl/input_sync.sv
// Three-stage synchroniser with agreement filter for one pin
`timescale 1ns/1ns
module input_sync (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Pin and filtered level
  input  wire logic pin_i,
  output logic      level_o
);
  logic ff1;
  logic ff2;
  logic ff3;

  always_ff @(posedge clk_i)
  begin
    ff1 <= pin_i;
    ff2 <= ff1;
    ff3 <= ff2;
  end

  // Level changes only once the second and third stages agree
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      level_o <= 1'b1;
    else if (ff2 == ff3)
      level_o <= ff3;
  end
endmodule

// ### test/speed_threshold_props.sv
// Concurrent checks on the relay controller ports
`timescale 1ns/1ns
module speed_threshold_props #(
  parameter logic [31:0] CYCLES_PER_MS = 32'd100000
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        sensor_i,
  input wire logic        override_n_i,
  input wire logic        clear_n_i,
  input wire logic        relay_o,
  input wire logic        relay_led_o,
  input wire logic        input_led_o
);
  localparam int WIN = 5 * CYCLES_PER_MS - 1;
  logic [2:0]  mode_seen;
  logic        relay_q;
  logic [15:0] since_chg;
  logic [4:0]  quiet;
  logic        latch_mode;
  assign latch_mode = (mode_seen == 3'h2) || (mode_seen == 3'h5) || (mode_seen == 3'h6);
  // Mirror the mode field from acknowledged control writes
  always_ff @(posedge clk_i)
    if (rst_i)
      mode_seen <= 3'h1;
    else if (wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == 8'h00 && wb_sel_i[0])
      mode_seen <= wb_dat_i[2:0];
  // Cycles since the relay last moved, and since the control pins were last active
  always_ff @(posedge clk_i)
  begin
    relay_q   <= relay_o;
    since_chg <= (rst_i || relay_o != relay_q) ? 16'h0000 :
                 (since_chg == 16'hFFFF) ? since_chg : since_chg + 16'h0001;
    quiet     <= (rst_i || !override_n_i || !clear_n_i) ? 5'h00 :
                 (quiet == 5'h1F) ? quiet : quiet + 5'h01;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_led_tracks_relay: assert property (relay_led_o == relay_o)
    else $error("relay indicator differs from relay");
  a_reset_release: assert property (disable iff (1'b0) rst_i |=> !relay_o && !relay_led_o)
    else $error("relay not released after reset");
  a_override_holds: assert property (!override_n_i [*8] |-> !relay_o)
    else $error("relay tripped while override held");
  a_input_led_high: assert property (sensor_i [*7] |-> input_led_o)
    else $error("input indicator not following high sensor");
  a_input_led_low: assert property (!sensor_i [*7] |-> !input_led_o)
    else $error("input indicator not following low sensor");
  a_latch_holds: assert property ((latch_mode && clear_n_i && override_n_i) [*8]
    |-> !$fell(relay_o))
    else $error("latched relay released without clear");
  a_window_spacing: assert property ($changed(relay_o) && quiet == 5'h1F |-> since_chg >= WIN)
    else $error("relay decisions closer than the window");
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not acknowledged next cycle");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");
  a_unmapped_zero: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o
    && wb_adr_i == 8'h14 |=> wb_dat_o == 32'h00000000)
    else $error("unmapped read returned data");
  c_relay_trip: cover property ($rose(relay_o));
  c_override_trip: cover property (!override_n_i && relay_o);
  c_latch_clear: cover property (latch_mode && !clear_n_i && $fell(relay_o));
endmodule

// ### test/sensor_gen.sv
// Sensor pulse source: one falling edge per period, idle high at zero speed
`timescale 1ns/1ns
module sensor_gen (
  input  wire logic       clk_i,
  input  wire logic [7:0] period_i,
  output logic            sensor_o
);
  logic [7:0] cnt = 8'h00;
  initial sensor_o = 1'b1;
  always @(posedge clk_i)
  begin
    if (period_i == 8'h00)
    begin
      cnt      <= 8'h00;
      sensor_o <= 1'b1;
    end
    else
    begin
      cnt      <= (cnt + 8'h01 >= period_i) ? 8'h00 : cnt + 8'h01;
      sensor_o <= (cnt < period_i / 2);
    end
  end
endmodule

// ### test/testbench.sv
// Self-checking bench for the speed threshold relay controller
`timescale 1ns/1ns
`include "speed_threshold_defines.svh"
module testbench;
  localparam int O = 1;
  localparam int U = 2;
  localparam int OV = 256;
  localparam int CL = 512;
  localparam int TRIP_V = 97000;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        sensor_i;
  logic        override_n_i = 1'b1;
  logic        clear_n_i = 1'b1;
  logic        relay_o;
  logic        relay_led_o;
  logic        input_led_o;
  logic [7:0]  period = 8'h00;
  int          n_fail = 0;
  int          checked = 0;
  int          rel;
  int          sup;
  // Mode, offset step, hysteresis step, then phases up to -1
  int plan [$] = {1, 0, 0, 14, O, 14, O, O + OV, O, O + CL, 14, -1,
                  2, 0, 0, O, O + CL, 14, 14 + CL, -1,
                  3, 0, 0, 8, U, 0, 8, -1,
                  4, 0, 0, U, 8, U, -1,
                  5, 0, 0, 8, U, 8, 8 + CL, -1,
                  6, 0, 0, U, 8, U, 8, 8 + CL, -1,
                  1, 9, 0, 8, 7, -1,
                  3, 9, 0, 14, 16, -1,
                  3, 0, 5, U, 10, -1,
                  3, 0, 0, U, 10, -1,
                  1, 0, 9, 7, 11, -1};
  always #5 clk_i = ~clk_i;
  speed_threshold_relay_control #(
    .CYCLES_PER_MS  (32'd10),
    .MAX_PERIOD_CYC (32'd2000)
  ) i_dut (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .wb_cyc_i     (wb_cyc_i),
    .wb_stb_i     (wb_stb_i),
    .wb_we_i      (wb_we_i),
    .wb_adr_i     (wb_adr_i),
    .wb_sel_i     (wb_sel_i),
    .wb_dat_i     (wb_dat_i),
    .wb_dat_o     (wb_dat_o),
    .wb_ack_o     (wb_ack_o),
    .sensor_i     (sensor_i),
    .override_n_i (override_n_i),
    .clear_n_i    (clear_n_i),
    .relay_o      (relay_o),
    .relay_led_o  (relay_led_o),
    .input_led_o  (input_led_o)
  );
  sensor_gen i_sensor (.clk_i(clk_i), .period_i(period), .sensor_o(sensor_i));
  task automatic test_done();
    if (n_fail == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One classic Wishbone cycle, entered just after a rising edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1);
    check("bus ack latency", 2, n);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  function automatic int frac(input int s);
    case (s)
      5: return `FRAC_5;
      9: return `FRAC_9;
      default: return 0;
    endcase
  endfunction
  task automatic start_case(input int mode, input int ofs, input int hys);
    logic [31:0] q;
    // Idle sensor while the new set-up is written, so the first window is not mixed
    period <= 8'h00;
    rst_i  <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b1, 8'h00, 4'hF, (hys << 12) | (ofs << 8) | mode, q);
    wb(1'b1, 8'h04, 4'hF, TRIP_V, q);
    rel = 0;
    sup = (mode == 4 || mode == 6);
  endtask
  // Run one steady input condition, then compare with the reference decision
  task automatic phase(input int mode, input int ofs, input int hys, input int ph);
    int p;
    int f;
    int tp;
    int rp;
    int over;
    int tr;
    int rr;
    p = ph % 256;
    if (p == O)
      p = 6 + $urandom % 3;
    else if (p == U)
      p = 12 + $urandom % 4;
    period       <= p[7:0];
    override_n_i <= (ph & OV) == 0;
    clear_n_i    <= (ph & CL) == 0;
    repeat (300) @(posedge clk_i);
    f = (p == 0) ? 0 : 1000000 / p;
    over = mode < 3;
    tp = over ? TRIP_V + ((TRIP_V * frac(ofs)) >> 16) : TRIP_V - ((TRIP_V * frac(ofs)) >> 16);
    rp = (hys == 0) ? tp : over ? tp - ((TRIP_V * frac(hys)) >> 16)
                                : tp + ((TRIP_V * frac(hys)) >> 16);
    tr = over ? f > tp : f < tp;
    rr = over ? f < rp : f > rp;
    if (rr)
      sup = 0;
    if ((ph & OV) != 0)
      rel = 0;
    else if (tr && !sup)
      rel = 1;
    else if (rr && (!(mode == 2 || mode == 5 || mode == 6) || (ph & CL) != 0))
      rel = 0;
    check("relay", rel, relay_o);
    check("relay indicator", rel, relay_led_o);
  endtask
  initial
  begin
    logic [31:0] q;
    logic [31:0] e;
    int          i;
    int          m;
    void'($urandom(72));
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check("relay after reset", 0, relay_o);
    wb(1'b0, 8'h00, 4'hF, 0, q);
    check("control reset", 32'h00001001, q);
    wb(1'b0, 8'h04, 4'hF, 0, q);
    check("trip reset", 32'h000F4240, q);
    wb(1'b1, 8'h04, 4'h1, 32'hFFFFFFFF, q);
    wb(1'b0, 8'h04, 4'hF, 0, q);
    check("trip byte write", 32'h000F42FF, q);
    wb(1'b1, 8'h00, 4'hF, 32'hFFFFFFFF, q);
    wb(1'b0, 8'h00, 4'hF, 0, q);
    check("control mask", 32'h0000FFF7, q);
    wb(1'b1, 8'h14, 4'hF, 32'hFFFFFFFF, q);
    wb(1'b0, 8'h14, 4'hF, 0, q);
    check("unmapped read", 32'h00000000, q);
    i = 0;
    while (i < plan.size())
    begin
      m = plan[i];
      start_case(m, plan[i + 1], plan[i + 2]);
      i += 3;
      while (plan[i] != -1)
      begin
        phase(m, plan_ofs(i), plan_hys(i), plan[i]);
        i++;
      end
      i++;
    end
    wb(1'b0, 8'h0C, 4'hF, 0, e);
    wb(1'b0, 8'h10, 4'hF, 0, q);
    check("window average", 1, (q + 1 >= e * 11) && (q <= e * 11 + 1));
    test_done();
  end
  // Offset and hysteresis of the case that holds plan entry k
  function automatic int case_start(input int k);
    int s;
    s = 0;
    for (int j = 0; j < k; j++)
      if (plan[j] == -1)
        s = j + 1;
    return s;
  endfunction
  function automatic int plan_ofs(input int k);
    return plan[case_start(k) + 1];
  endfunction
  function automatic int plan_hys(input int k);
    return plan[case_start(k) + 2];
  endfunction
  initial
  begin
    repeat (60000) @(posedge clk_i);
    n_fail++;
    test_done();
  end
endmodule
bind speed_threshold_relay_control speed_threshold_props #(
  .CYCLES_PER_MS (CYCLES_PER_MS)
) i_props (
  .clk_i        (clk_i),
  .rst_i        (rst_i),
  .wb_cyc_i     (wb_cyc_i),
  .wb_stb_i     (wb_stb_i),
  .wb_we_i      (wb_we_i),
  .wb_adr_i     (wb_adr_i),
  .wb_sel_i     (wb_sel_i),
  .wb_dat_i     (wb_dat_i),
  .wb_dat_o     (wb_dat_o),
  .wb_ack_o     (wb_ack_o),
  .sensor_i     (sensor_i),
  .override_n_i (override_n_i),
  .clear_n_i    (clear_n_i),
  .relay_o      (relay_o),
  .relay_led_o  (relay_led_o),
  .input_led_o  (input_led_o)
);
